// ===== tb.sv
/*
  Self-checking bench of the endpoint 0 control engine: register port,
  interrupt request and control transfers through the host model.
  Assumes the engine answers handshakes one cycle after the event.
*/
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module tb;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWrStb = 1'b0;
  logic       regRdStb = 1'b0;
  logic [7:0] regRdData_r;
  logic       tokValid, pktDone, pktErr, rxByte, hostAck;
  logic [1:0] tokPid;
  logic [6:0] pktLen;
  logic [6:0] inPktLen = 7'h40;
  logic       hsValid_r, txStart_r, usbIrq_r;
  logic [1:0] hsCode_r;
  logic [1:0] lastHs = 2'h3;
  logic       ep0IrqEn = 1'b1;
  logic [2:1] outEpPend = 2'h0;
  logic [3:0] commonPend = 4'h0;
  int         failures = 0;
  int         total_checks = 0;
  int         hsCnt = 0;
  int         txCnt = 0;
  int         cycles = 0;
  int         seed = 55650;
  int         n;
  logic [7:0] d, e1, e2;
  logic [31:0] r;

  always #2 clk_sys = ~clk_sys;

  ue0_ctrl_engine ue0_ctrl_engine_inst (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_r(regRdData_r),
    .tokValid(tokValid), .tokPid(tokPid), .pktDone(pktDone), .pktErr(pktErr), .pktLen(pktLen),
    .rxByte(rxByte), .hostAck(hostAck), .inPktLen(inPktLen), .hsValid_r(hsValid_r),
    .hsCode_r(hsCode_r), .txStart_r(txStart_r), .ep0IrqEn(ep0IrqEn), .outEpPend(outEpPend),
    .commonPend(commonPend), .usbIrq_r(usbIrq_r));
  ue0_host_model ue0_host_model_inst (.clk_sys(clk_sys), .tokValid(tokValid), .tokPid(tokPid),
    .pktDone(pktDone), .pktErr(pktErr), .pktLen(pktLen), .rxByte(rxByte), .hostAck(hostAck));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= v;
    regWrStb  <= 1'b1;
    @(posedge clk_sys);
    regWrStb  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 v = regRdData_r;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic idle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic expHs(input int base, input logic [1:0] code);
    chk(8'(hsCnt - base), 8'h01);
    chk({6'h00, lastHs}, {6'h00, code});
  endtask
  function automatic logic [7:0] irqExp(input logic [7:0] oe, input logic [7:0] ce, input logic [31:0] p);
    return {7'h00, (|(p[2:1] & oe[2:1])) | (|(p[6:3] & ce[3:0]))};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // answers are counted here so no pulse is missed between checks
  always @(posedge clk_sys) begin
    if (hsValid_r === 1'b1) begin
      hsCnt  <= hsCnt + 1;
      lastHs <= hsCode_r;
    end
    if (txStart_r === 1'b1) txCnt <= txCnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(8'h0E, 8'h00);
    rdChk(8'h09, 8'h06);
    rdChk(8'h0B, 8'h06);
    rdChk(8'h3F, 8'h00);
    // random enables and pending flags, first pass all ones except ep0IrqEn
    for (int i = 0; i < 12; i++) begin
      e1 = (i == 0) ? 8'hFF : 8'($random(seed));
      e2 = (i == 0) ? 8'hFF : 8'($random(seed));
      r  = (i == 0) ? 32'h0000007E : 32'($random(seed));
      wr(8'h09, e1);
      wr(8'h0B, e2);
      rdChk(8'h09, e1 & 8'h06);
      rdChk(8'h0B, e2 & 8'h0F);
      @(posedge clk_sys);
      ep0IrqEn   <= r[0];
      outEpPend  <= r[2:1];
      commonPend <= r[6:3];
      repeat (3) @(posedge clk_sys);
      #1 chk({7'h00, usbIrq_r}, irqExp(e1, e2, r));
    end
    @(posedge clk_sys);
    ep0IrqEn   <= 1'b1;
    outEpPend  <= 2'h0;
    commonPend <= 4'h0;
    // good SETUP
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_SETUP);
    ue0_host_model_inst.sendData(7'h08, 1'b0);
    idle();
    expHs(n, ue0_pkg::HS_ACK);
    chk({7'h00, usbIrq_r}, 8'h01);
    rdChk(8'h11, 8'h01);
    rdChk(8'h16, 8'h08);
    rdChk(8'h02, 8'h01);
    wr(8'h11, 8'h40);
    rdChk(8'h11, 8'h00);
    // short SETUP and corrupt OUT draw no answer
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_SETUP);
    ue0_host_model_inst.sendData(7'h07, 1'b0);
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_OUT);
    ue0_host_model_inst.sendData(7'h00, 1'b1);
    idle();
    chk(8'(hsCnt - n), 8'h00);
    rdChk(8'h11, 8'h00);
    chk({7'h00, usbIrq_r}, 8'h00);
    rdChk(8'h02, 8'h00);
    // the corrupt OUT packet left receive mode on; a zero-length OUT closes it
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_OUT);
    ue0_host_model_inst.sendData(7'h00, 1'b0);
    idle();
    expHs(n, ue0_pkg::HS_ACK);
    rdChk(8'h02, 8'h01);
    wr(8'h11, 8'h40);
    // IN with nothing loaded
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_IN);
    idle();
    expHs(n, ue0_pkg::HS_NAK);
    rdChk(8'h02, 8'h00);
    // full IN packet, interrupt only after host ack
    n = txCnt;
    wr(8'h11, 8'h02);
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_IN);
    idle();
    chk(8'(txCnt - n), 8'h01);
    rdChk(8'h02, 8'h00);
    ue0_host_model_inst.sendAck();
    idle();
    rdChk(8'h11, 8'h00);
    rdChk(8'h02, 8'h01);
    // SETUP while transmitting ends the transfer early
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_SETUP);
    ue0_host_model_inst.sendData(7'h08, 1'b0);
    idle();
    rdChk(8'h11, 8'h11);
    rdChk(8'h02, 8'h01);
    wr(8'h11, 8'hC0);
    rdChk(8'h11, 8'h00);
    // short last IN then zero-length status OUT
    @(posedge clk_sys);
    inPktLen <= 7'h05;
    wr(8'h11, 8'h0A);
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_IN);
    ue0_host_model_inst.sendAck();
    idle();
    rdChk(8'h02, 8'h01);
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_OUT);
    ue0_host_model_inst.sendData(7'h00, 1'b0);
    idle();
    expHs(n, ue0_pkg::HS_ACK);
    rdChk(8'h02, 8'h01);
    rd(8'h11, d);
    chk(d & 8'h08, 8'h00);
    // firmware stall request
    wr(8'h11, 8'h20);
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_IN);
    idle();
    expHs(n, ue0_pkg::HS_STALL);
    rd(8'h11, d);
    chk(d & 8'h24, 8'h04);
    rdChk(8'h02, 8'h01);
    wr(8'h11, 8'h00);
    // oversize OUT packet
    n = hsCnt;
    ue0_host_model_inst.sendTok(ue0_pkg::TOK_OUT);
    ue0_host_model_inst.sendData(7'h41, 1'b0);
    idle();
    expHs(n, ue0_pkg::HS_STALL);
    rd(8'h11, d);
    chk(d & 8'h04, 8'h04);
    final_report();
  end
endmodule

// ===== ue0_ctrl_engine.sv
/*
  Endpoint 0 control engine of a full speed USB function: control-transfer
  modes, automatic handshakes and stalls, endpoint 0 flags and interrupt
  enables behind a simple byte register port.
  Assumes a serial engine that decodes tokens and packets for endpoint 0 and
  reports them as one-cycle pulses synchronous to clk_sys, never two of
  tokValid, pktDone and hostAck in the same cycle; FIFO storage lives outside.
*/
`timescale 1ns/100ps
`include "ue0_params.svh"

module ue0_ctrl_engine (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData_r,
  // serial engine events
  input  wire logic       tokValid,
  input  wire logic [1:0] tokPid,
  input  wire logic       pktDone,
  input  wire logic       pktErr,
  input  wire logic [6:0] pktLen,
  input  wire logic       rxByte,
  input  wire logic       hostAck,
  input  wire logic [6:0] inPktLen,
  // serial engine answers
  output logic            hsValid_r,
  output logic      [1:0] hsCode_r,
  output logic            txStart_r,
  // interrupt sources kept elsewhere
  input  wire logic       ep0IrqEn,
  input  wire logic [2:1] outEpPend,
  input  wire logic [3:0] commonPend,
  output logic            usbIrq_r
);

  ue0_pkg::ue0_mode_t mode_r;
  ue0_pkg::ue0_mode_t modeNxt;
  ue0_pkg::ue0_tok_t  dataTok_r;
  logic [7:0] outEn_r, cmnEn_r, epSel_r, byteCnt_r;
  logic       outRdy_r, inRdy_r, setupEnd_r, data_end_a_r, sentStall_r, stallReq_r, ep0Pend_r;
  logic       txStat_r, txBusy_r;
  logic       evStall, evSuEnd, evOutRdy, evInDone, evStatDone, hsGo, txGo, txStatGo;
  ue0_pkg::ue0_hs_t hsSel;
  logic       wrEp0, wrSel, ep0Sel;

  assign ep0Sel = (epSel_r == 8'h00);
  assign wrSel  = regWrStb && (regAddr == `UE0_OFS_EP0_STATUS);
  // writes to the status register land only with endpoint 0 selected
  assign wrEp0  = wrSel && ep0Sel;

  ////////////////////////////////////////////////////////////////////////////
  // token and packet decisions
  always_comb begin
    evStall    = 1'b0;
    evSuEnd    = 1'b0;
    evOutRdy   = 1'b0;
    evInDone   = 1'b0;
    evStatDone = 1'b0;
    hsGo       = 1'b0;
    hsSel      = ue0_pkg::HS_ACK;
    txGo       = 1'b0;
    txStatGo   = 1'b0;
    modeNxt    = mode_r;
    if (tokValid) begin
      unique case (tokPid)
        ue0_pkg::TOK_SETUP: begin
          if (mode_r != ue0_pkg::MODE_IDLE && !data_end_a_r) begin
            evSuEnd = 1'b1;
          end
          modeNxt = ue0_pkg::MODE_IDLE;
        end
        ue0_pkg::TOK_OUT: begin
          if (stallReq_r) begin
            evStall = 1'b1;
          end else if (mode_r == ue0_pkg::MODE_TX) begin
            evSuEnd = !data_end_a_r;
            modeNxt = data_end_a_r ? ue0_pkg::MODE_STAT : ue0_pkg::MODE_IDLE;
          end else if (mode_r == ue0_pkg::MODE_RX && data_end_a_r) begin
            evStall = 1'b1;
          end else if (mode_r == ue0_pkg::MODE_IDLE) begin
            modeNxt = ue0_pkg::MODE_RX;
          end
        end
        ue0_pkg::TOK_IN: begin
          if (stallReq_r) begin
            evStall = 1'b1;
          end else if (mode_r == ue0_pkg::MODE_RX && !data_end_a_r) begin
            evSuEnd = 1'b1;
            modeNxt = ue0_pkg::MODE_IDLE;
            hsGo    = 1'b1;
            hsSel   = ue0_pkg::HS_NAK;
          end else if (mode_r != ue0_pkg::MODE_TX && data_end_a_r && !inRdy_r) begin
            // status stage of an OUT transfer; a loaded single IN packet goes first
            txStatGo = 1'b1;
          end else if (inRdy_r) begin
            txGo    = 1'b1;
            modeNxt = ue0_pkg::MODE_TX;
          end else if (mode_r == ue0_pkg::MODE_TX && data_end_a_r) begin
            evStall = 1'b1;
          end else begin
            hsGo    = 1'b1;
            hsSel   = ue0_pkg::HS_NAK;
            modeNxt = ue0_pkg::MODE_TX;
          end
        end
        default: begin
        end
      endcase
    end else if (pktDone && !pktErr) begin
      if (dataTok_r == ue0_pkg::TOK_SETUP) begin
        // only 8-byte SETUP data is taken
        if (pktLen == `UE0_SETUP_LEN) begin
          evOutRdy = 1'b1;
          hsGo     = 1'b1;
        end
      end else if (dataTok_r == ue0_pkg::TOK_OUT) begin
        if (pktLen > `UE0_MAX_PKT) begin
          evStall = 1'b1;
        end else if (mode_r == ue0_pkg::MODE_STAT) begin
          evStall    = (pktLen != 7'h00);
          evStatDone = (pktLen == 7'h00);
          hsGo       = (pktLen == 7'h00);
          modeNxt    = ue0_pkg::MODE_IDLE;
        end else if (mode_r == ue0_pkg::MODE_RX) begin
          hsGo     = 1'b1;
          hsSel    = outRdy_r ? ue0_pkg::HS_NAK : ue0_pkg::HS_ACK;
          evOutRdy = !outRdy_r;
          // short or empty packet ends receive mode
          if (!outRdy_r && pktLen < `UE0_MAX_PKT) begin
            modeNxt = ue0_pkg::MODE_IDLE;
          end
        end
      end
    end else if (hostAck && txBusy_r) begin
      if (txStat_r) begin
        modeNxt = ue0_pkg::MODE_IDLE;
      end else begin
        evInDone = 1'b1;
        // short or zero-length packet ends transmit mode
        if (inPktLen < `UE0_MAX_PKT) begin
          modeNxt = data_end_a_r ? ue0_pkg::MODE_STAT : ue0_pkg::MODE_IDLE;
        end
      end
    end
    if (evStall) begin
      hsGo  = 1'b1;
      hsSel = ue0_pkg::HS_STALL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, data context and answers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= ue0_pkg::MODE_IDLE;
    end else begin
      mode_r <= modeNxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dataTok_r <= ue0_pkg::TOK_NONE;
    end else if (tokValid) begin
      dataTok_r <= (tokPid == ue0_pkg::TOK_IN) ? ue0_pkg::TOK_NONE : ue0_pkg::ue0_tok_t'(tokPid);
    end else if (pktDone) begin
      dataTok_r <= ue0_pkg::TOK_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hsValid_r <= 1'b0;
      hsCode_r  <= ue0_pkg::HS_ACK;
      txStart_r <= 1'b0;
    end else begin
      hsValid_r <= hsGo;
      hsCode_r  <= hsSel;
      txStart_r <= txGo || txStatGo;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txBusy_r <= 1'b0;
      txStat_r <= 1'b0;
    end else if (txGo || txStatGo) begin
      txBusy_r <= 1'b1;
      txStat_r <= txStatGo;
    end else if (hostAck || tokValid) begin
      // a lost handshake ends the attempt; the host retries with a new IN
      txBusy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // endpoint 0 flags; hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outRdy_r <= 1'b0;
    end else if (evOutRdy) begin
      outRdy_r <= 1'b1;
    end else if (wrEp0 && regWrData[`UE0_B_SRV_OUT_PKT]) begin
      outRdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      inRdy_r <= 1'b0;
    end else if (wrEp0 && regWrData[`UE0_B_IN_PKT_RDY]) begin
      inRdy_r <= 1'b1;
    end else if (evInDone) begin
      inRdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      setupEnd_r <= 1'b0;
    end else if (evSuEnd) begin
      setupEnd_r <= 1'b1;
    end else if (wrEp0 && regWrData[`UE0_B_SRV_SETUP_END]) begin
      setupEnd_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_end_a_r <= 1'b0;
    end else if (evStatDone || (hostAck && txBusy_r && txStat_r) || evStall ||
                 (tokValid && tokPid == ue0_pkg::TOK_SETUP)) begin
      // hardware clear at end of transfer
      data_end_a_r <= 1'b0;
    end else if (wrEp0 && regWrData[`UE0_B_DATA_END]) begin
      data_end_a_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sentStall_r <= 1'b0;
    end else if (evStall) begin
      sentStall_r <= 1'b1;
    end else if (wrEp0 && !regWrData[`UE0_B_SENT_STALL]) begin
      sentStall_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stallReq_r <= 1'b0;
    end else if (evStall && stallReq_r) begin
      stallReq_r <= 1'b0;
    end else if (wrEp0) begin
      stallReq_r <= regWrData[`UE0_B_STALL_REQ];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byteCnt_r <= 8'h00;
    end else if (tokValid && tokPid != ue0_pkg::TOK_IN && !outRdy_r) begin
      byteCnt_r <= 8'h00;
    end else if (rxByte && !outRdy_r && dataTok_r != ue0_pkg::TOK_NONE) begin
      byteCnt_r <= byteCnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pending and request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ep0Pend_r <= 1'b0;
    end else if (evOutRdy || evInDone || evStatDone || evStall || evSuEnd) begin
      ep0Pend_r <= 1'b1;
    end else if (regRdStb && regAddr == `UE0_OFS_EP0_PEND) begin
      ep0Pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      usbIrq_r <= 1'b0;
    end else begin
      usbIrq_r <= (ep0Pend_r && ep0IrqEn) || |(outEpPend & outEn_r[2:1]) || |(commonPend & cmnEn_r[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      outEn_r <= `UE0_OUT_EN_RESET;
      cmnEn_r <= `UE0_CMN_EN_RESET;
      epSel_r <= 8'h00;
    end else if (regWrStb) begin
      if (regAddr == `UE0_OFS_OUT_IRQ_EN) begin
        outEn_r <= regWrData & `UE0_OUT_EN_MASK;
      end
      if (regAddr == `UE0_OFS_CMN_IRQ_EN) begin
        cmnEn_r <= regWrData & `UE0_CMN_EN_MASK;
      end
      if (regAddr == `UE0_OFS_EP_SELECT) begin
        epSel_r <= regWrData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData_r <= 8'h00;
    end else if (regRdStb) begin
      unique case (regAddr)
        `UE0_OFS_EP0_PEND:   regRdData_r <= {7'h00, ep0Pend_r};
        `UE0_OFS_OUT_IRQ_EN: regRdData_r <= outEn_r;
        `UE0_OFS_CMN_IRQ_EN: regRdData_r <= cmnEn_r;
        `UE0_OFS_EP_SELECT:  regRdData_r <= epSel_r;
        `UE0_OFS_EP0_STATUS: regRdData_r <= ep0Sel ? {2'b00, stallReq_r, setupEnd_r, data_end_a_r,
                                                      sentStall_r, inRdy_r, outRdy_r} : 8'h00;
        `UE0_OFS_EP0_COUNT:  regRdData_r <= ep0Sel ? byteCnt_r : 8'h00;
        default:             regRdData_r <= 8'h00;
      endcase
    end else begin
      regRdData_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_enable_unused_zero: assert property (outEn_r[7:3] == 5'h00 && !outEn_r[0] && cmnEn_r[7:4] == 4'h0)
    else $error("unused enable bit set");
  chk_bad_setup_drop: assert property (pktDone && dataTok_r == ue0_pkg::TOK_SETUP && pktLen != `UE0_SETUP_LEN
                                       |=> !hsValid_r && $stable(outRdy_r))
    else $error("wrong-length setup accepted");
  chk_err_no_irq: assert property (pktDone && pktErr && !ep0Pend_r |=> !ep0Pend_r)
    else $error("errored packet raised interrupt");
  chk_nak_no_ready: assert property (tokValid && tokPid == ue0_pkg::TOK_IN && !inRdy_r && !data_end_a_r &&
                                     !stallReq_r && mode_r != ue0_pkg::MODE_RX
                                     |=> hsValid_r && hsCode_r == ue0_pkg::HS_NAK && !txStart_r)
    else $error("IN without packet not NAKed");
  chk_stall_flags: assert property (hsValid_r && hsCode_r == ue0_pkg::HS_STALL |-> sentStall_r && ep0Pend_r)
    else $error("stall without flag");
  chk_in_done_clear: assert property (hostAck && txBusy_r && !txStat_r
                                      |=> !inRdy_r || $past(wrEp0))
    else $error("in ready not cleared");
  chk_setup_end_set: assert property (tokValid && tokPid == ue0_pkg::TOK_SETUP && mode_r == ue0_pkg::MODE_TX &&
                                      !data_end_a_r |=> setupEnd_r && ep0Pend_r)
    else $error("setup end missed");
  chk_stall_req_clear: assert property (stallReq_r && tokValid && tokPid != ue0_pkg::TOK_SETUP
                                        |=> !stallReq_r ##1 !hsValid_r)
    else $error("stall request not cleared");
  chk_irq_follows: assert property (ep0Pend_r && ep0IrqEn |=> usbIrq_r)
    else $error("interrupt not raised");

  cov_setup_taken:   cover property (evOutRdy && dataTok_r == ue0_pkg::TOK_SETUP);
  cov_in_status:     cover property (evStatDone);
  cov_protocol_stall: cover property (evStall && !stallReq_r);

endmodule

// ===== ue0_host_model.sv
/*
  Host and serial engine stand-in for endpoint 0: tokens, data packets
  and host acks as one-cycle pulses on the engine event ports.
  Assumes the caller waits for the answer before the next transfer.
*/
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module ue0_host_model (
  // clock
  input  wire logic       clk_sys,
  // serial engine events
  output logic            tokValid,
  output logic      [1:0] tokPid,
  output logic            pktDone,
  output logic            pktErr,
  output logic      [6:0] pktLen,
  output logic            rxByte,
  output logic            hostAck
);
  initial begin
    tokValid = 1'b0;
    tokPid   = 2'h3;
    pktDone  = 1'b0;
    pktErr   = 1'b0;
    pktLen   = 7'h00;
    rxByte   = 1'b0;
    hostAck  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // unqualified fields are inverted after each pulse so stale values are not held
  task automatic sendTok(input logic [1:0] pid);
    @(posedge clk_sys);
    tokValid <= 1'b1;
    tokPid   <= pid;
    @(posedge clk_sys);
    tokValid <= 1'b0;
    tokPid   <= ~pid;
  endtask
  task automatic sendData(input logic [6:0] len, input logic err);
    repeat (len) begin
      @(posedge clk_sys);
      rxByte <= 1'b1;
      @(posedge clk_sys);
      rxByte <= 1'b0;
    end
    @(posedge clk_sys);
    pktDone <= 1'b1;
    pktLen  <= len;
    pktErr  <= err;
    @(posedge clk_sys);
    pktDone <= 1'b0;
    pktLen  <= ~len;
    pktErr  <= ~err;
  endtask
  task automatic sendAck();
    @(posedge clk_sys);
    hostAck <= 1'b1;
    @(posedge clk_sys);
    hostAck <= 1'b0;
  endtask
endmodule

// ===== ue0_params.svh
/*
  Constants of the endpoint 0 control engine: register offsets, bit positions,
  reset values and packet sizes. Assumes it is included by bare name only.
*/
`ifndef UE0_PARAMS_SVH
`define UE0_PARAMS_SVH

// register offsets
`define UE0_OFS_EP0_PEND     8'h02
`define UE0_OFS_OUT_IRQ_EN   8'h09
`define UE0_OFS_CMN_IRQ_EN   8'h0B
`define UE0_OFS_EP_SELECT    8'h0E
`define UE0_OFS_EP0_STATUS   8'h11
`define UE0_OFS_EP0_COUNT    8'h16

// enable register layout and reset values
`define UE0_OUT_EN_MASK      8'h06
`define UE0_OUT_EN_RESET     8'h06
`define UE0_CMN_EN_MASK      8'h0F
`define UE0_CMN_EN_RESET     8'h06

// endpoint 0 status register bit positions
`define UE0_B_SRV_SETUP_END  7
`define UE0_B_SRV_OUT_PKT    6
`define UE0_B_STALL_REQ      5
`define UE0_B_SETUP_END      4
`define UE0_B_DATA_END       3
`define UE0_B_SENT_STALL     2
`define UE0_B_IN_PKT_RDY     1
`define UE0_B_OUT_PKT_RDY    0

// packet sizes in bytes
`define UE0_MAX_PKT          7'h40
`define UE0_SETUP_LEN        7'h08

`endif

// ===== ue0_pkg.sv
/*
  Types of the endpoint 0 control engine: endpoint mode, token kinds and
  handshake codes. Assumes nothing of its surroundings.
*/
package ue0_pkg;

  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0001,
    MODE_TX   = 4'b0010,
    MODE_RX   = 4'b0100,
    MODE_STAT = 4'b1000
  } ue0_mode_t;

  typedef enum logic [1:0] {
    TOK_SETUP = 2'h0,
    TOK_OUT   = 2'h1,
    TOK_IN    = 2'h2,
    TOK_NONE  = 2'h3
  } ue0_tok_t;

  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2
  } ue0_hs_t;

endpackage
